// ---- common/wwdt_pkg.sv ----
// Purpose: constants and types shared by the windowed watchdog timer
// Assumes: 32-bit AXI4-Lite register access, one 25 MHz clock
// Notes:   offsets are byte addresses of aligned words
package wwdt_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ  = 25_000_000;
  localparam int unsigned RC_FREQ_HZ   = 32_000;
  // rc clock is modelled as an enable pulse every RC_TICK_DIV cycles
  localparam int unsigned RC_TICK_DIV  = CLK_FREQ_HZ / RC_FREQ_HZ;
  localparam int unsigned DIV_W        = $clog2(RC_TICK_DIV);
  // prescaler stage widths: divide-by-32 and divide-by-128
  localparam int unsigned PRE_SHORT_W  = 5;
  localparam int unsigned PRE_LONG_W   = 7;
  localparam int unsigned POST_MAX     = 15;
  localparam int unsigned CNT_W        = PRE_LONG_W + POST_MAX;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RCTRL  = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;

  // wd_config_word fields
  localparam int unsigned CFG_W        = 10;
  localparam int unsigned CFG_POST_LSB = 0;
  localparam int unsigned CFG_PRE_BIT  = 4;
  localparam int unsigned CFG_WDIS_BIT = 6;
  localparam int unsigned CFG_HEN_BIT  = 7;
  localparam int unsigned CFG_WIN_LSB  = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h04f;

  // reset_control_register fields
  localparam int unsigned RC_IDLE_BIT  = 2;
  localparam int unsigned RC_SLEEP_BIT = 3;
  localparam int unsigned RC_TO_BIT    = 4;
  localparam int unsigned RC_SWEN_BIT  = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WWDT_REG_CONFIG, WWDT_REG_RCTRL, WWDT_REG_COUNT,
                            WWDT_REG_NONE} wwdt_reg_e;
  typedef enum logic [1:0] {WWDT_RUN, WWDT_SLEEP, WWDT_IDLE} wwdt_pmode_e;
endpackage

// ---- test/wwdt_core_model.sv ----
// Purpose: core side that issues clear, power-save, switch and wake events
// Assumes: op is held for one cycle per request
// Notes:   op 1 clear, 2 sleep, 3 idle, 4 clock switch, 5 other wake
`timescale 1ns/1ps
module wwdt_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] op,
  input  wire logic       wd_wake,
  output logic            wd_clear_instruction,
  output logic            power_save_instruction,
  output logic            power_save_idle,
  output logic            clock_switch_done,
  output logic            wake_request,
  output logic            asleep
);
  // ----------------------------------------------------------------
  // event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_clear_instruction   <= 1'b0;
      power_save_instruction <= 1'b0;
      power_save_idle        <= 1'b0;
      clock_switch_done      <= 1'b0;
      wake_request           <= 1'b0;
      asleep                 <= 1'b0;
    end else begin
      // a stopped core cannot execute a clear
      wd_clear_instruction   <= op == 3'h1 && !asleep;
      power_save_instruction <= op == 3'h2 || op == 3'h3;
      power_save_idle        <= op == 3'h3;
      clock_switch_done      <= op == 3'h4;
      wake_request           <= op == 3'h5;
      // execution resumes where it stopped once woken
      if (op == 3'h2 || op == 3'h3) asleep <= 1'b1;
      else if (wd_wake || op == 3'h5) asleep <= 1'b0;
    end
  end
endmodule

// ---- test/wwdt_props.sv ----
// Purpose: concurrent checks on the watchdog top-level ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound into wwdt_top, sees its ports only
`timescale 1ns/1ps
module wwdt_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        low_power_rc_on,
  input wire logic        wd_wake,
  input wire logic        wd_device_reset
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_ANSWER: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  AST_R_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data missing");
  AST_SLVERR: assert property (ar_taken ##0 (s_axi_araddr == 8'h0c) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  AST_REL_QUIET: assert property ($rose(aresetn) |->
    !low_power_rc_on && !wd_wake && !wd_device_reset) else $error("outputs busy after reset");
  AST_WAKE_PULSE: assert property (wd_wake |=> !wd_wake)
    else $error("wake pulse too long");
  AST_RST_PULSE: assert property (wd_device_reset |=> !wd_device_reset)
    else $error("reset pulse too long");
  AST_RST_NEEDS_RC: assert property (wd_device_reset |-> $past(low_power_rc_on))
    else $error("failure without running clock");
endmodule
bind wwdt_top wwdt_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .low_power_rc_on, .wd_wake, .wd_device_reset);

// ---- test/wwdt_top_bench.sv ----
// Purpose: register and event tests of the windowed watchdog
// Assumes: shortest period, 1:32 and 1:1, about 25000 cycles
// Notes:   pulses are sampled on the edge that shows them
`timescale 1ns/1ps
module wwdt_top_bench;
  import wwdt_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic rc_on, wake, dev_rst, clr, ps, ps_idle, sw, wreq, asleep;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp;
  logic [2:0] op = 3'h0;
  int n_errors = 0, n_checks = 0, cyc = 0, n;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  always #20 aclk = ~aclk;
  wwdt_top u_wwdt_top (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wd_clear_instruction(clr), .power_save_instruction(ps), .power_save_idle(ps_idle),
    .clock_switch_done(sw), .wake_request(wreq), .low_power_rc_on(rc_on),
    .wd_wake(wake), .wd_device_reset(dev_rst));
  wwdt_core_model u_wwdt_core_model (.aclk, .aresetn, .op, .wd_wake(wake),
    .wd_clear_instruction(clr), .power_save_instruction(ps), .power_save_idle(ps_idle),
    .clock_switch_done(sw), .wake_request(wreq), .asleep);
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // the whole run needs about 75000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ga, gw;
    ga = 0;
    gw = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin ga = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin gw = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic core(input logic [2:0] c);
    @(posedge aclk);
    op <= c;
    @(posedge aclk);
    op <= 3'h0;
  endtask
  task automatic wait_pulse(input bit wk, input int lim);
    n = 0;
    do begin @(posedge aclk); n++; end while ((wk ? wake : dev_rst) !== 1'b1 && n < lim);
    if ((wk ? wake : dev_rst) !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t pulse missing", $time);
    end
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CONFIG, d, r); chk(d, 32'h04f);
    rd(OFS_RCTRL, d, r); chk(d, 32'h0);
    rd(8'h0c, d, r); chk({d[31:2], r}, {30'h0, RESP_SLVERR});
    chk(rc_on, 1'b0);
    $display("test 1 done");
    wr(OFS_CONFIG, 32'h040);
    wr(OFS_RCTRL, 32'h20);
    repeat (3) @(posedge aclk);
    chk(rc_on, 1'b1);
    repeat (781 * 4) @(posedge aclk);
    rd(OFS_COUNT, d, r); chk(d >= 3 && d <= 5, 1'b1);
    core(3'h1); rd(OFS_COUNT, d, r); chk(d < 2, 1'b1);
    repeat (781 * 3) @(posedge aclk);
    core(3'h4); rd(OFS_COUNT, d, r); chk(d < 2, 1'b1);
    $display("test 2 done");
    wait_pulse(0, 27000); chk(n >= 24000 && n <= 25800, 1'b1);
    rd(OFS_RCTRL, d, r); chk(d, 32'h10);
    chk(rc_on, 1'b0);
    wr(OFS_RCTRL, 32'h0); rd(OFS_RCTRL, d, r); chk(d, 32'h0);
    $display("test 3 done");
    wr(OFS_CONFIG, 32'h0c0);
    repeat (3) @(posedge aclk);
    chk(rc_on, 1'b1);
    core(3'h3); core(3'h5); rd(OFS_RCTRL, d, r); chk(d, 32'h04);
    rd(OFS_COUNT, d, r); chk(d < 2, 1'b1);
    core(3'h2); rd(OFS_RCTRL, d, r); chk(d, 32'h0c);
    wait_pulse(1, 27000); chk(n > 24000, 1'b1);
    @(posedge aclk);
    chk(asleep, 1'b0);
    rd(OFS_RCTRL, d, r); chk(d, 32'h1c);
    wr(OFS_RCTRL, 32'h0); rd(OFS_RCTRL, d, r); chk(d, 32'h0);
    $display("test 4 done");
    wr(OFS_CONFIG, 32'h080);
    core(3'h4); repeat (781 * 10) @(posedge aclk);
    core(3'h1); rd(OFS_COUNT, d, r); chk(d < 2, 1'b1);
    rd(OFS_RCTRL, d, r); chk(d, 32'h0);
    core(3'h1);
    wait_pulse(0, 6);
    rd(OFS_RCTRL, d, r); chk(d, 32'h10);
    wr(OFS_RCTRL, 32'h0); wr(OFS_CONFIG, 32'h180);
    repeat (781 * 12) @(posedge aclk);
    core(3'h1);
    wait_pulse(0, 6);
    rd(OFS_RCTRL, d, r); chk(d, 32'h10);
    $display("test 5 done");
    give_verdict();
  end
endmodule

// ---- verilog/wwdt_top.sv ----
// Purpose: windowed watchdog timer with AXI4-Lite register access
// Assumes: core event inputs are one-cycle pulses on aclk
// Notes:   prescaler and postscaler form one combined binary counter
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
#(
  // aclk cycles per rc clock period; the rc clock is an enable, not a clock
  parameter int unsigned RC_DIV = wwdt_pkg::RC_TICK_DIV
)
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [wwdt_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [wwdt_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         wd_clear_instruction,
  input  wire logic                         power_save_instruction,
  input  wire logic                         power_save_idle,
  input  wire logic                         clock_switch_done,
  input  wire logic                         wake_request,
  output logic                              low_power_rc_on,
  output logic                              wd_wake,
  output logic                              wd_device_reset
);
  import wwdt_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the tick divider is sized by the package; a larger ratio would wrap early
  if (RC_DIV < 2 || $clog2(RC_DIV) > DIV_W) begin : g_bad_rc_div
    $error("rc divider does not fit the tick counter");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [CNT_W-1:0] count;
    logic [CFG_W-1:0] cfg;
    logic             soft_en;
    logic             to_flag;
    logic             sleep_flag;
    logic             idle_flag;
    wwdt_pmode_e      pmode;
    logic             rc_on;
    logic             wake;
    logic             wdrst;
    logic             aw_full;
    logic             w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } wwdt_state_s;

  wwdt_state_s q;
  wwdt_state_s next_q;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic wwdt_reg_e reg_sel(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_CONFIG: reg_sel = WWDT_REG_CONFIG;
      OFS_RCTRL:  reg_sel = WWDT_REG_RCTRL;
      OFS_COUNT:  reg_sel = WWDT_REG_COUNT;
      default:    reg_sel = WWDT_REG_NONE;
    endcase
  endfunction

  // full period in rc ticks: prescale times postscale
  function automatic logic [CNT_W:0] period_of(input logic [CFG_W-1:0] cfg);
    logic [4:0] sh;
    sh = cfg[CFG_PRE_BIT] ? 5'(PRE_LONG_W) : 5'(PRE_SHORT_W);
    sh = sh + 5'(cfg[CFG_POST_LSB +: 4]);
    period_of = (CNT_W+1)'(1) << sh;
  endfunction

  // count at which the clear window opens
  function automatic logic [CNT_W:0] win_open(input logic [CFG_W-1:0] cfg);
    logic [CNT_W:0] p;
    p = period_of(cfg);
    case (cfg[CFG_WIN_LSB +: 2])
      2'h3:    win_open = p - (p >> 2);
      2'h2:    win_open = p - (p >> 2) - (p >> 3);
      2'h1:    win_open = p >> 1;
      default: win_open = p >> 2;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic             enabled;
  logic             tick;
  logic             timeout;
  logic             early_clear;
  logic             fail;
  logic             do_write;
  logic [31:0]      rc_word;
  logic [31:0]      wmask;

  always_comb begin
    next_q  = q;
    next_q.wake  = 1'b0;
    next_q.wdrst = 1'b0;
    rc_word = 32'h0;
    rc_word[RC_IDLE_BIT]  = q.idle_flag;
    rc_word[RC_SLEEP_BIT] = q.sleep_flag;
    rc_word[RC_TO_BIT]    = q.to_flag;
    rc_word[RC_SWEN_BIT]  = q.soft_en;
    wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};

    // register writes first, so hardware sets below win over clears
    do_write = q.aw_full && q.w_full;
    if (do_write) begin
      next_q.aw_full = 1'b0;
      next_q.w_full  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = RESP_OKAY;
      case (reg_sel(q.awaddr))
        WWDT_REG_CONFIG: begin
          next_q.cfg = (q.cfg & ~wmask[CFG_W-1:0]) | (q.wdata[CFG_W-1:0] & wmask[CFG_W-1:0]);
        end
        WWDT_REG_RCTRL: begin
          if (q.wstrb[0]) begin
            next_q.soft_en = q.wdata[RC_SWEN_BIT];
            // status bits clear on writing 0, writing 1 leaves them
            next_q.to_flag    = q.to_flag && q.wdata[RC_TO_BIT];
            next_q.sleep_flag = q.sleep_flag && q.wdata[RC_SLEEP_BIT];
            next_q.idle_flag  = q.idle_flag && q.wdata[RC_IDLE_BIT];
          end
        end
        WWDT_REG_COUNT: begin
        end
        default: begin
          next_q.bresp = RESP_SLVERR;
        end
      endcase
    end

    // watchdog core
    enabled = q.cfg[CFG_HEN_BIT] || q.soft_en;
    next_q.rc_on = enabled;
    tick = 1'b0;
    if (enabled) begin
      if (q.div == DIV_W'(RC_DIV - 1)) begin
        next_q.div = '0;
        tick = 1'b1;
      end else begin
        next_q.div = q.div + DIV_W'(1);
      end
    end else begin
      next_q.div = '0;
    end
    timeout = tick && ({1'b0, q.count} == period_of(q.cfg) - (CNT_W+1)'(1));
    early_clear = enabled && wd_clear_instruction && (q.pmode == WWDT_RUN)
                  && !q.cfg[CFG_WDIS_BIT]
                  && ({1'b0, q.count} < win_open(q.cfg));
    fail = timeout || early_clear;

    if (!enabled) begin
      next_q.count = '0;
    end else if (tick) begin
      next_q.count = q.count + CNT_W'(1);
    end

    if (clock_switch_done) begin
      next_q.div   = '0;
      next_q.count = '0;
    end
    if (wd_clear_instruction && q.pmode == WWDT_RUN) begin
      next_q.div   = '0;
      next_q.count = '0;
    end
    if (power_save_instruction && q.pmode == WWDT_RUN) begin
      next_q.div   = '0;
      next_q.count = '0;
      next_q.pmode = power_save_idle ? WWDT_IDLE : WWDT_SLEEP;
      if (power_save_idle) begin
        next_q.idle_flag = 1'b1;
      end else begin
        next_q.sleep_flag = 1'b1;
      end
    end
    if (wake_request && q.pmode != WWDT_RUN) begin
      next_q.div   = '0;
      next_q.count = '0;
      next_q.pmode = WWDT_RUN;
    end

    // a failure overrides every other event in the same cycle except a power-save entry, which still sets its mode and flag
    if (fail) begin
      next_q.to_flag = 1'b1;
      next_q.div     = '0;
      next_q.count   = '0;
      if (q.pmode != WWDT_RUN) begin
        // status bit stays set; software owns its clear
        next_q.pmode = WWDT_RUN;
        next_q.wake  = 1'b1;
      end else begin
        next_q.wdrst   = 1'b1;
        next_q.soft_en = 1'b0;
      end
    end

    // bus handshakes
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_full = 1'b1;
      next_q.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_full = 1'b1;
      next_q.wdata  = s_axi_wdata;
      next_q.wstrb  = s_axi_wstrb;
    end
    next_q.awready = !next_q.aw_full && !next_q.bvalid;
    next_q.wready  = !next_q.w_full && !next_q.bvalid;

    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = RESP_OKAY;
      next_q.rdata  = 32'h0;
      case (reg_sel(s_axi_araddr))
        WWDT_REG_CONFIG: next_q.rdata[CFG_W-1:0] = q.cfg;
        WWDT_REG_RCTRL:  next_q.rdata = rc_word;
        WWDT_REG_COUNT:  next_q.rdata[CNT_W-1:0] = q.count;
        default:         next_q.rresp = RESP_SLVERR;
      endcase
    end
    next_q.arready = !next_q.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all counts and the soft enable start from zero after a device reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.cfg        <= CFG_RESET;
      q.pmode      <= WWDT_RUN;
      q.awready    <= 1'b1;
      q.wready     <= 1'b1;
      q.arready    <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready   = q.awready;
  assign s_axi_wready    = q.wready;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = q.arready;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rresp     = q.rresp;
  assign s_axi_rdata     = q.rdata;
  assign low_power_rc_on = q.rc_on;
  assign wd_wake         = q.wake;
  assign wd_device_reset = q.wdrst;
endmodule
